// ===== hw/scld_debounce.sv
/*
 * Card-detect filter: three-stage synchroniser, unit prescaler and unit count.
 * Assumes the detect pin is asynchronous and active low.
 */
`timescale 1ns/10ps
module scld_debounce #(
	parameter int UNIT_CYCLES = scld_pkg::DEB_UNIT_CYCLES
) (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic media_card_detect_n_i,
	scld_if.flt bus
);
	typedef struct packed {
		logic [scld_pkg::SYNC_STAGES-1:0] sync;
		logic stable_n;
		logic changed;
		logic [scld_pkg::PRE_W-1:0] pre;
		logic [7:0] units;
	} scld_deb_s;

	localparam scld_deb_s RST = '{sync: '1, stable_n: 1'h1, changed: 1'h0,
		pre: '0, units: 8'h00};
	localparam logic [scld_pkg::PRE_W-1:0] PRE_LAST = scld_pkg::PRE_W'(UNIT_CYCLES - 1);

	scld_deb_s st;
	scld_deb_s next_st;
	logic agree;
	logic cand;

	assign agree = st.sync[1] == st.sync[2];
	assign cand = st.sync[2];
	assign bus.card_present = ~st.stable_n;
	assign bus.detect_changed = st.changed;

	// ------------------------------------------------------------
	// Filter
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.sync = {st.sync[1:0], media_card_detect_n_i};
		next_st.changed = 1'h0;
		if (!agree || cand == st.stable_n) begin
			next_st.pre = '0;
			next_st.units = 8'h00;
		end else if (st.units == bus.deb_value) begin
			next_st.stable_n = cand;
			next_st.changed = 1'h1;
			next_st.pre = '0;
			next_st.units = 8'h00;
		end else if (st.pre == PRE_LAST) begin
			next_st.pre = '0;
			next_st.units = st.units + 8'h01;
		end else begin
			next_st.pre = st.pre + scld_pkg::PRE_W'(1);
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			st <= RST;
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);

	a_accept_agree: assert property (
		$changed(st.stable_n) |-> $past(agree))
		else $error("filtered state changed while synchroniser disagreed");
	a_accept_full: assert property (
		$changed(st.stable_n) |->
		$past(st.units) == $past(bus.deb_value))
		else $error("filtered state changed before full interval");
	c_detect_change: cover property (st.changed);
endmodule

// ===== hw/scld_if.sv
/*
 * Carrier between the register bank and the card-detect filter.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/10ps
interface scld_if;
	logic [7:0] deb_value;
	logic card_present;
	logic detect_changed;
	modport ctl (
		output deb_value,
		input card_present,
		input detect_changed
	);
	modport flt (
		input deb_value,
		output card_present,
		output detect_changed
	);
endinterface

// ===== hw/scld_pkg.sv
/*
 * Constants for the system control low bits and card-detect debounce bank.
 * Assumes byte-addressed configuration accesses on dword-aligned offsets.
 */
package scld_pkg;
	localparam logic [7:0] SYSCTL_OFS = 8'h80;
	localparam logic [7:0] DEBOUNCE_OFS = 8'h84;
	localparam logic [1:0] FUNC_0 = 2'h0;
	localparam logic [1:0] FUNC_1 = 2'h1;
	localparam int BIT_MUX = 0;
	localparam int BIT_KEEP = 1;
	localparam int BIT_VOLT = 2;
	localparam int BIT_RSVD3 = 3;
	localparam int BIT_PAR = 4;
	localparam int BIT_LOCK = 5;
	localparam logic LOCK_RST = 1'h1;
	localparam logic PAR_RST = 1'h0;
	localparam logic RSVD3_RST = 1'h0;
	localparam logic KEEP_RST = 1'h0;
	localparam logic MUX_RST = 1'h0;
	localparam logic [7:0] DEBOUNCE_RST = 8'h19;
	localparam int CLK_KHZ = 125000;
	localparam int DEB_UNIT_MS = 2;
	localparam int DEB_UNIT_CYCLES = DEB_UNIT_MS * CLK_KHZ;
	localparam int PRE_W = 24;
	localparam int SYNC_STAGES = 3;
endpackage

// ===== hw/scld_top.sv
/*
 * System control low bits and card-detect debounce register bank.
 * Assumes byte-addressed configuration cycles with byte enables on the
 * system clock, and same-clock event and enable inputs from the core.
 */
`timescale 1ns/10ps
module scld_top #(
	parameter int UNIT_CYCLES = scld_pkg::DEB_UNIT_CYCLES
) (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic pci_rst_n_i,
	input wire logic cfg_wr_i,
	input wire logic cfg_rd_i,
	input wire logic [1:0] cfg_func_i,
	input wire logic [7:0] cfg_addr_i,
	input wire logic [3:0] cfg_be_i,
	input wire logic [31:0] cfg_wdata_i,
	output logic [31:0] cfg_rdata_o,
	input wire logic legacy_socket_voltage_i,
	input wire logic card_parity_err_i,
	input wire logic pme_i,
	input wire logic ring_indicate_output_i,
	input wire logic ring_output_enable_i,
	input wire logic media_card_detect_n_i,
	output logic ident_write_enable_o,
	output logic serr_o,
	output logic clock_hold_o,
	output logic shared_wake_ring_pin_o,
	output logic shared_wake_ring_pin_oe_o,
	output logic card_present_o,
	output logic card_detect_change_o
);
	typedef struct packed {
		logic lock;
		logic par_fwd;
		logic rsvd3;
		logic volt;
		logic keep;
		logic mux;
		logic [7:0] deb;
		logic [31:0] rdata;
		logic id_we;
		logic serr;
		logic clk_hold;
		logic pin_out;
		logic pin_oe;
		logic present;
		logic det_chg;
	} scld_top_s;

	localparam scld_top_s RST = '{
		lock: scld_pkg::LOCK_RST,
		par_fwd: scld_pkg::PAR_RST,
		rsvd3: scld_pkg::RSVD3_RST,
		volt: 1'h0,
		keep: scld_pkg::KEEP_RST,
		mux: scld_pkg::MUX_RST,
		deb: scld_pkg::DEBOUNCE_RST,
		rdata: 32'h00000000,
		id_we: ~scld_pkg::LOCK_RST,
		serr: 1'h0,
		clk_hold: scld_pkg::KEEP_RST,
		pin_out: 1'h0,
		pin_oe: 1'h0,
		present: 1'h0,
		det_chg: 1'h0
	};

	scld_top_s st;
	scld_top_s next_st;
	scld_if bus ();

	logic func_ok;
	logic hit_sys;
	logic hit_deb;
	logic wr_lane0;
	logic [5:0] sys_view;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	// Functions 0 and 1 reach the same storage; other functions see nothing.
	assign func_ok = (cfg_func_i == scld_pkg::FUNC_0) || (cfg_func_i == scld_pkg::FUNC_1);
	assign hit_sys = func_ok && cfg_addr_i == scld_pkg::SYSCTL_OFS;
	assign hit_deb = func_ok && cfg_addr_i == scld_pkg::DEBOUNCE_OFS;
	// Writes are held off while the bus-side reset is asserted.
	assign wr_lane0 = cfg_wr_i && cfg_be_i[0] && pci_rst_n_i;

	always_comb begin
		sys_view = 6'h00;
		sys_view[scld_pkg::BIT_MUX] = st.mux;
		sys_view[scld_pkg::BIT_KEEP] = st.keep;
		sys_view[scld_pkg::BIT_VOLT] = st.volt;
		sys_view[scld_pkg::BIT_RSVD3] = st.rsvd3;
		sys_view[scld_pkg::BIT_PAR] = st.par_fwd;
		sys_view[scld_pkg::BIT_LOCK] = st.lock;
	end

	// ------------------------------------------------------------
	// Card-detect filter
	// ------------------------------------------------------------
	assign bus.deb_value = st.deb;

	scld_debounce #(
		.UNIT_CYCLES(UNIT_CYCLES)
	) u_debounce (
		.clk_sys_i(clk_sys_i),
		.nrst_i(nrst_i),
		.media_card_detect_n_i(media_card_detect_n_i),
		.bus(bus.flt)
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.volt = legacy_socket_voltage_i;
		if (wr_lane0 && hit_sys) begin
			next_st.mux = cfg_wdata_i[scld_pkg::BIT_MUX];
			next_st.keep = cfg_wdata_i[scld_pkg::BIT_KEEP];
			next_st.rsvd3 = cfg_wdata_i[scld_pkg::BIT_RSVD3];
			next_st.par_fwd = cfg_wdata_i[scld_pkg::BIT_PAR];
			next_st.lock = cfg_wdata_i[scld_pkg::BIT_LOCK];
		end
		if (wr_lane0 && hit_deb) begin
			next_st.deb = cfg_wdata_i[7:0];
		end
		next_st.rdata = 32'h00000000;
		if (cfg_rd_i && hit_sys) begin
			next_st.rdata = {26'h0, sys_view};
		end else if (cfg_rd_i && hit_deb) begin
			next_st.rdata = {24'h000000, st.deb};
		end
		next_st.id_we = ~next_st.lock;
		next_st.serr = card_parity_err_i && st.par_fwd;
		next_st.clk_hold = next_st.keep;
		if (next_st.mux) begin
			next_st.pin_oe = 1'h1;
			next_st.pin_out = pme_i;
		end else if (ring_output_enable_i) begin
			next_st.pin_oe = 1'h1;
			next_st.pin_out = ring_indicate_output_i;
		end else begin
			next_st.pin_oe = 1'h0;
			next_st.pin_out = 1'h0;
		end
		next_st.present = bus.card_present;
		next_st.det_chg = bus.detect_changed;
		// Bus-side reset clears read data and serr but keeps all settings.
		if (!pci_rst_n_i) begin
			next_st.rdata = 32'h00000000;
			next_st.serr = 1'h0;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			st <= RST;
		end else begin
			st <= next_st;
		end
	end

	assign cfg_rdata_o = st.rdata;
	assign ident_write_enable_o = st.id_we;
	assign serr_o = st.serr;
	assign clock_hold_o = st.clk_hold;
	assign shared_wake_ring_pin_o = st.pin_out;
	assign shared_wake_ring_pin_oe_o = st.pin_oe;
	assign card_present_o = st.present;
	assign card_detect_change_o = st.det_chg;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);

	a_ident_gate: assert property (
		wr_lane0 && hit_sys |=>
		ident_write_enable_o == !$past(cfg_wdata_i[scld_pkg::BIT_LOCK]))
		else $error("identification write enable does not follow lock bit");
	a_parity_fwd: assert property (
		card_parity_err_i && pci_rst_n_i |=>
		serr_o == $past(st.par_fwd))
		else $error("parity error forwarding wrong");
	a_volt_read: assert property (
		cfg_rd_i && hit_sys && pci_rst_n_i |=>
		cfg_rdata_o[scld_pkg::BIT_VOLT] == $past(st.volt))
		else $error("voltage bit read back wrong");
	a_volt_ro: assert property (
		wr_lane0 && hit_sys |=> st.volt == $past(legacy_socket_voltage_i))
		else $error("voltage bit taken from write data");
	a_clock_keep: assert property (
		wr_lane0 && hit_sys |=>
		clock_hold_o == $past(cfg_wdata_i[scld_pkg::BIT_KEEP]))
		else $error("clock hold does not follow written bit");
	a_pin_pme: assert property (
		st.mux |-> shared_wake_ring_pin_oe_o &&
		shared_wake_ring_pin_o == $past(pme_i))
		else $error("wake event not driven on shared pin");
	// The first edge after reset still shows the reset pin state
	a_pin_ring: assert property (
		$past(nrst_i) && !st.mux && $past(ring_output_enable_i) |->
		shared_wake_ring_pin_oe_o &&
		shared_wake_ring_pin_o == $past(ring_indicate_output_i))
		else $error("ring output not driven on shared pin");
	a_pin_float: assert property (
		!st.mux && !$past(ring_output_enable_i) |->
		!shared_wake_ring_pin_oe_o)
		else $error("shared pin driven while deselected");
	a_deb_reset: assert property (
		$rose(nrst_i) |-> st.deb == scld_pkg::DEBOUNCE_RST)
		else $error("debounce register reset value wrong");
	a_deb_keep: assert property (
		!pci_rst_n_i |=> st.deb == $past(st.deb))
		else $error("debounce register disturbed by bus reset");
	a_deb_write: assert property (
		wr_lane0 && hit_deb |=> st.deb == $past(cfg_wdata_i[7:0]))
		else $error("debounce register write lost");
	a_deb_func1: assert property (
		cfg_rd_i && hit_deb && cfg_func_i == scld_pkg::FUNC_1 &&
		pci_rst_n_i |=> cfg_rdata_o[7:0] == $past(st.deb))
		else $error("debounce register not visible in function 1");
	a_shared_copy: assert property (
		wr_lane0 && hit_sys && cfg_func_i == scld_pkg::FUNC_1 |=>
		st.par_fwd == $past(cfg_wdata_i[scld_pkg::BIT_PAR]))
		else $error("function 1 write missed shared bit");

	c_pme_drive: cover property (st.mux && shared_wake_ring_pin_o);
	c_ring_drive: cover property (!st.mux && shared_wake_ring_pin_oe_o);
	c_func1_write: cover property (wr_lane0 && hit_deb && cfg_func_i == scld_pkg::FUNC_1);
	c_present: cover property ($rose(card_present_o));
endmodule

// ===== verif/scld_socket_model.sv
/*
 * Card socket model: the detect contact as the block's far side sees it.
 * Assumes the bench commands insertion and chatter on the system clock.
 */
`timescale 1ns/10ps
module scld_socket_model (
	input wire logic clk_sys_i,
	input wire logic card_in_i,
	input wire logic chatter_i,
	output logic media_card_detect_n_o
);
	// Contact pulls low with a card seated, pull-up wins otherwise
	always_ff @(posedge clk_sys_i) begin
		if (chatter_i) begin
			media_card_detect_n_o <= ~media_card_detect_n_o;
		end else begin
			media_card_detect_n_o <= ~card_in_i;
		end
	end
endmodule

// ===== verif/sysctl_low_bits_card_debounce_tb_top.sv
/*
 * Self-checking bench for the control bits and card-detect debounce bank.
 * Assumes the design is built with a short debounce unit of 4 cycles.
 */
`timescale 1ns/10ps
module sysctl_low_bits_card_debounce_tb_top;
	localparam int UC = 4;
	logic clk_sys_i = 1'b0;
	logic nrst_i = 1'b0;
	logic pci_rst_n_i = 1'b1;
	logic cfg_wr_i = 1'b0;
	logic cfg_rd_i = 1'b0;
	logic [1:0] cfg_func_i = 2'h0;
	logic [7:0] cfg_addr_i = 8'h00;
	logic [3:0] cfg_be_i = 4'h1;
	logic [31:0] cfg_wdata_i = 32'h0;
	logic [31:0] cfg_rdata_o;
	logic legacy_socket_voltage_i = 1'b0;
	logic card_parity_err_i = 1'b0;
	logic pme_i = 1'b0;
	logic ring_indicate_output_i = 1'b0;
	logic ring_output_enable_i = 1'b0;
	logic media_card_detect_n_i;
	logic ident_write_enable_o, serr_o, clock_hold_o;
	logic shared_wake_ring_pin_o, shared_wake_ring_pin_oe_o;
	logic card_present_o, card_detect_change_o;
	logic card_in = 1'b0;
	logic chatter = 1'b0;
	int miscompares = 0;
	int n_compared = 0;

	initial forever #4 clk_sys_i = ~clk_sys_i;

	scld_top #(.UNIT_CYCLES(UC)) DUT (.clk_sys_i, .nrst_i, .pci_rst_n_i, .cfg_wr_i,
		.cfg_rd_i, .cfg_func_i, .cfg_addr_i, .cfg_be_i, .cfg_wdata_i, .cfg_rdata_o,
		.legacy_socket_voltage_i, .card_parity_err_i, .pme_i, .ring_indicate_output_i,
		.ring_output_enable_i, .media_card_detect_n_i, .ident_write_enable_o, .serr_o,
		.clock_hold_o, .shared_wake_ring_pin_o, .shared_wake_ring_pin_oe_o,
		.card_present_o, .card_detect_change_o);

	scld_socket_model sock (.clk_sys_i(clk_sys_i), .card_in_i(card_in),
		.chatter_i(chatter), .media_card_detect_n_o(media_card_detect_n_i));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic summarize();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic do_reset();
		@(posedge clk_sys_i);
		nrst_i <= 1'b0;
		repeat (12) @(posedge clk_sys_i);
		nrst_i <= 1'b1;
	endtask

	task automatic wr(input logic [1:0] f, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		cfg_wr_i <= 1'b1;
		cfg_func_i <= f;
		cfg_addr_i <= a;
		cfg_wdata_i <= d;
		@(posedge clk_sys_i);
		cfg_wr_i <= 1'b0;
		#1;
	endtask

	task automatic rchk(input logic [1:0] f, input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys_i);
		cfg_rd_i <= 1'b1;
		cfg_func_i <= f;
		cfg_addr_i <= a;
		@(posedge clk_sys_i);
		cfg_rd_i <= 1'b0;
		#1;
		chk("cfg_rdata_o", cfg_rdata_o, e);
	endtask

	task automatic parity_pulse();
		@(posedge clk_sys_i);
		card_parity_err_i <= 1'b1;
		@(posedge clk_sys_i);
		card_parity_err_i <= 1'b0;
		#1;
	endtask

	task automatic wait_chg(output int n);
		n = 0;
		while (card_detect_change_o !== 1'b1) begin
			@(posedge clk_sys_i);
			#1;
			n++;
			if (n > 60) begin
				miscompares++;
				summarize();
			end
		end
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_defaults();
		rchk(2'h0, 8'h84, 32'h19);
		rchk(2'h1, 8'h84, 32'h19);
		rchk(2'h0, 8'h80, 32'h20);
		chk("ident_we", 32'(ident_write_enable_o), 32'h0);
		rchk(2'h2, 8'h84, 32'h0);
		$display("t_defaults done");
	endtask

	task automatic t_ctl();
		wr(2'h0, 8'h80, 32'h16);
		rchk(2'h0, 8'h80, 32'h12);
		legacy_socket_voltage_i <= 1'b1;
		rchk(2'h0, 8'h80, 32'h16);
		chk("ident_we", 32'(ident_write_enable_o), 32'h1);
		chk("clock_hold", 32'(clock_hold_o), 32'h1);
		parity_pulse();
		chk("serr_on", 32'(serr_o), 32'h1);
		wr(2'h0, 8'h80, 32'h20);
		parity_pulse();
		chk("serr_off", 32'(serr_o), 32'h0);
		chk("clock_free", 32'(clock_hold_o), 32'h0);
		$display("t_ctl done");
	endtask

	task automatic t_pin();
		logic [2:0] i;
		for (int k = 0; k < 8; k++) begin
			i = 3'(k);
			wr(2'h0, 8'h80, {31'h10, i[1]});
			pme_i <= i[2];
			ring_indicate_output_i <= ~i[2];
			ring_output_enable_i <= i[0];
			repeat (2) @(posedge clk_sys_i);
			#1;
			chk("pin_oe", 32'(shared_wake_ring_pin_oe_o), 32'(i[1] | i[0]));
			if (i[1] | i[0]) begin
				chk("pin", 32'(shared_wake_ring_pin_o), 32'(i[1] ? i[2] : !i[2]));
			end
		end
		$display("t_pin done");
	endtask

	task automatic t_shared();
		wr(2'h1, 8'h80, 32'h22);
		rchk(2'h0, 8'h80, 32'h26);
		chk("clock_hold", 32'(clock_hold_o), 32'h1);
		wr(2'h0, 8'h80, 32'h20);
		wr(2'h1, 8'h84, 32'h2);
		pci_rst_n_i <= 1'b0;
		wr(2'h0, 8'h84, 32'h7);
		pci_rst_n_i <= 1'b1;
		rchk(2'h0, 8'h84, 32'h2);
		$display("t_shared done");
	endtask

	task automatic t_debounce();
		int n;
		logic seen;
		card_in <= 1'b1;
		wait_chg(n);
		chk("insert_delay", 32'(n >= 2 * UC + 5 && n <= 2 * UC + 7), 32'h1);
		@(posedge clk_sys_i);
		#1;
		chk("present", 32'(card_present_o), 32'h1);
		card_in <= 1'b0;
		repeat (5) @(posedge clk_sys_i);
		card_in <= 1'b1;
		@(posedge clk_sys_i);
		card_in <= 1'b0;
		#1;
		wait_chg(n);
		chk("bounce_delay", 32'(n >= 2 * UC && n <= 2 * UC + 10), 32'h1);
		@(posedge clk_sys_i);
		#1;
		chk("absent", 32'(card_present_o), 32'h0);
		// Zero interval: only synchroniser agreement guards against chatter
		wr(2'h0, 8'h84, 32'h0);
		chatter <= 1'b1;
		repeat (6) @(posedge clk_sys_i);
		chatter <= 1'b0;
		seen = 1'b0;
		repeat (20) begin
			@(posedge clk_sys_i);
			#1;
			seen = seen | card_detect_change_o;
		end
		chk("chatter_chg", 32'(seen), 32'h0);
		card_in <= 1'b1;
		wait_chg(n);
		chk("zero_delay", 32'(n >= 5 && n <= 7), 32'h1);
		@(posedge clk_sys_i);
		#1;
		chk("zero_present", 32'(card_present_o), 32'h1);
		$display("t_debounce done");
	endtask

	initial begin
		do_reset();
		t_defaults();
		t_ctl();
		t_pin();
		t_shared();
		t_debounce();
		do_reset();
		rchk(2'h0, 8'h84, 32'h19);
		$display("t_global_reset done");
		summarize();
	end
endmodule
